// ===== core/pms_top.sv
// phy management service: serves read, write, burst and transceiver-state requests
// assumes requester keeps one request outstanding; burst_done comes from the
// same-clock burst transmitter; all inputs are synchronous to clk
`timescale 1ns/10ps
module pms_top (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    attr_read_req,
    input  wire logic                    attr_write_req,
    input  wire logic                    burst_initiate_req,
    input  wire logic                    xcvr_state_set_req,
    input  wire logic [pms_pkg::ID_W-1:0]  attr_id,
    input  wire logic [pms_pkg::VAL_W-1:0] attr_value,
    input  wire logic [1:0]              xcvr_target_state,
    input  wire logic                    burst_done,
    output logic                         burst_start,
    output logic [1:0]                   xcvr_state,
    output logic                         cnf_valid,
    output logic [1:0]                   cnf_kind,
    output logic [1:0]                   cnf_status,
    output logic [pms_pkg::ID_W-1:0]     cnf_attr_id,
    output logic [pms_pkg::VAL_W-1:0]    cnf_value,
    output logic [pms_pkg::LEN_W-1:0]    cnf_value_len,
    output logic                         busy
);
    import pms_pkg::*;

    typedef enum logic [1:0] {PMS_IDLE, PMS_BURST} pms_state_t;
    pms_state_t state_q;

    pms_attr_if at ();
    pms_attr_tbl u_tbl (
        .clk    (clk),
        .resetn (resetn),
        .at     (at)
    );

    // request decode; requests are ignored while a burst is outstanding
    wire idle     = (state_q == PMS_IDLE);
    wire do_read  = idle && attr_read_req;
    wire do_write = idle && attr_write_req;
    wire do_burst = idle && burst_initiate_req;
    wire do_state = idle && xcvr_state_set_req;
    wire st_legal = (xcvr_target_state == XS_OFF) || (xcvr_target_state == XS_TX)
                 || (xcvr_target_state == XS_RX);
    wire burst_end = (state_q == PMS_BURST) && burst_done;

    assign at.id     = attr_id;
    assign at.wr_val = attr_value;
    assign at.wr_en  = do_write;

    // write status: absent id first, then range check
    wire [1:0] wr_status = !at.found    ? ST_NOT_FOUND
                         : !at.in_range ? ST_INVALID
                         :                ST_SUCCESS;
    wire [1:0] rd_status = at.found ? ST_SUCCESS : ST_NOT_FOUND;

    // controller: only the burst waits, everything else answers next cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PMS_IDLE;
        end else begin
            unique case (state_q)
                PMS_IDLE:  if (do_burst) state_q <= PMS_BURST;
                PMS_BURST: if (burst_done) state_q <= PMS_IDLE;
            endcase
        end
    end

    // transceiver state: illegal targets leave it in its current state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xcvr_state <= XS_OFF;
        end else if (do_state && st_legal) begin
            xcvr_state <= xcvr_target_state;
        end
    end

    // burst start pulse and busy level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            burst_start <= 1'b0;
            busy        <= 1'b0;
        end else begin
            burst_start <= do_burst;
            busy        <= (do_burst || (!idle && !burst_done));
        end
    end

    // confirm outputs: one pulse per request, matching kind
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnf_valid     <= 1'b0;
            cnf_kind      <= CK_READ;
            cnf_status    <= ST_SUCCESS;
            cnf_attr_id   <= '0;
            cnf_value     <= '0;
            cnf_value_len <= LEN_NONE;
        end else begin
            cnf_valid <= do_read || do_write || do_state || burst_end;
            if (do_read) begin
                cnf_kind      <= CK_READ;
                cnf_status    <= rd_status;
                cnf_attr_id   <= attr_id;
                cnf_value     <= at.found ? at.rd_val : '0;
                cnf_value_len <= at.found ? VAL_LEN : LEN_NONE;
            end else if (do_write) begin
                cnf_kind      <= CK_WRITE;
                cnf_status    <= wr_status;
                cnf_attr_id   <= attr_id;
                cnf_value     <= '0;
                cnf_value_len <= LEN_NONE;
            end else if (do_state) begin
                cnf_kind      <= CK_STATE;
                cnf_status    <= ST_COMPLETE;
                cnf_attr_id   <= '0;
                cnf_value     <= '0;
                cnf_value_len <= LEN_NONE;
            end else if (burst_end) begin
                cnf_kind      <= CK_BURST;
                cnf_status    <= ST_COMPLETE;
                cnf_attr_id   <= '0;
                cnf_value     <= '0;
                cnf_value_len <= LEN_NONE;
            end
        end
    end

    // helper: a state confirm must see the new state already in place
    logic [1:0] tgt_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) tgt_q <= XS_OFF;
        else if (do_state) tgt_q <= xcvr_target_state;
    end

    a_read_found: assert property (@(posedge clk) disable iff (!resetn)
        do_read && at.found |=> cnf_valid && cnf_kind == CK_READ && cnf_status == ST_SUCCESS
            && cnf_value == $past(at.rd_val))
        else $error("read of present attribute not confirmed with value");
    a_read_missing: assert property (@(posedge clk) disable iff (!resetn)
        do_read && !at.found |=> cnf_status == ST_NOT_FOUND)
        else $error("read of absent attribute not reported");
    a_read_empty: assert property (@(posedge clk) disable iff (!resetn)
        cnf_valid && cnf_kind == CK_READ |-> cnf_attr_id == $past(attr_id)
            && ((cnf_status == ST_NOT_FOUND) == (cnf_value_len == LEN_NONE)))
        else $error("read confirm id or value length wrong");
    a_burst_start: assert property (@(posedge clk) disable iff (!resetn)
        do_burst |=> burst_start && busy)
        else $error("burst request did not start burst");
    a_burst_after: assert property (@(posedge clk) disable iff (!resetn)
        cnf_valid && cnf_kind == CK_BURST |-> $past(burst_done) && !burst_start
            && cnf_status == ST_COMPLETE)
        else $error("burst confirm before burst sent");
    a_write_status: assert property (@(posedge clk) disable iff (!resetn)
        do_write && at.found && at.in_range |=> cnf_kind == CK_WRITE && cnf_status == ST_SUCCESS)
        else $error("good write not confirmed success");
    a_write_absent: assert property (@(posedge clk) disable iff (!resetn)
        do_write && !at.found |=> cnf_status == ST_NOT_FOUND)
        else $error("write to absent attribute not reported");
    a_write_range: assert property (@(posedge clk) disable iff (!resetn)
        do_write && at.found && !at.in_range |=> cnf_status == ST_INVALID
            && (at.id != $past(attr_id) || at.rd_val == $past(at.rd_val)))
        else $error("out-of-range write not rejected");
    a_write_id: assert property (@(posedge clk) disable iff (!resetn)
        cnf_valid && cnf_kind == CK_WRITE |-> cnf_attr_id == $past(attr_id)
            && cnf_status != ST_COMPLETE)
        else $error("write confirm id or status wrong");
    a_xcvr_legal: assert property (@(posedge clk) disable iff (!resetn)
        xcvr_state == XS_OFF || xcvr_state == XS_TX || xcvr_state == XS_RX)
        else $error("transceiver in undefined state");
    a_state_now: assert property (@(posedge clk) disable iff (!resetn)
        do_state && st_legal |=> cnf_valid && cnf_kind == CK_STATE
            && xcvr_state == $past(xcvr_target_state))
        else $error("state change not immediate");
    a_state_cnf: assert property (@(posedge clk) disable iff (!resetn)
        cnf_valid && cnf_kind == CK_STATE |-> cnf_status == ST_COMPLETE
            && (xcvr_state == tgt_q || !$past(st_legal)))
        else $error("state confirm without new state");
    a_one_cnf: assert property (@(posedge clk) disable iff (!resetn)
        do_burst |=> !cnf_valid)
        else $error("burst confirmed without waiting");
endmodule : pms_top

// ===== core/pms_pkg.sv
// package for the phy management service block: encodings, widths, table layout
// assumes a single 200 MHz clock domain; encodings are implementation choices
package pms_pkg;
    localparam int ID_W  = 8;
    localparam int VAL_W = 16;
    localparam int LEN_W = 5;
    localparam int N_ATTR = 4;
    // attribute identifiers and legal ranges (arbitrary implementation choice)
    localparam logic [ID_W-1:0]  ATTR_ID [N_ATTR]  = '{8'h00, 8'h01, 8'h02, 8'h03};
    localparam logic [VAL_W-1:0] ATTR_MIN [N_ATTR] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000};
    localparam logic [VAL_W-1:0] ATTR_MAX [N_ATTR] = '{16'h00FF, 16'h0003, 16'h003F, 16'hFFFF};
    localparam logic [VAL_W-1:0] ATTR_RST [N_ATTR] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000};
    // status encodings
    localparam logic [1:0] ST_SUCCESS   = 2'h0;
    localparam logic [1:0] ST_NOT_FOUND = 2'h1;
    localparam logic [1:0] ST_INVALID   = 2'h2;
    localparam logic [1:0] ST_COMPLETE  = 2'h3;
    // transceiver state encodings
    localparam logic [1:0] XS_OFF = 2'h0;
    localparam logic [1:0] XS_TX  = 2'h1;
    localparam logic [1:0] XS_RX  = 2'h2;
    // confirm kind encodings
    localparam logic [1:0] CK_READ  = 2'h0;
    localparam logic [1:0] CK_WRITE = 2'h1;
    localparam logic [1:0] CK_BURST = 2'h2;
    localparam logic [1:0] CK_STATE = 2'h3;
    // full value width in value-length units
    localparam logic [LEN_W-1:0] VAL_LEN = 5'h10;
    localparam logic [LEN_W-1:0] LEN_NONE = 5'h00;
endpackage : pms_pkg

// ===== core/pms_attr_if.sv
// interface between the request engine and the attribute table
// assumes both ends share clk
`timescale 1ns/10ps
interface pms_attr_if;
    import pms_pkg::*;
    logic [ID_W-1:0]  id;
    logic [VAL_W-1:0] wr_val;
    logic             wr_en;
    logic             found;
    logic             in_range;
    logic [VAL_W-1:0] rd_val;
    modport eng (output id, output wr_val, output wr_en,
                 input found, input in_range, input rd_val);
    modport tbl (input id, input wr_val, input wr_en,
                 output found, output in_range, output rd_val);
endinterface : pms_attr_if

// ===== core/pms_attr_tbl.sv
// attribute table: storage, lookup and range check
// assumes the engine holds id stable while it samples found and in_range
`timescale 1ns/10ps
module pms_attr_tbl (
    input wire logic clk,
    input wire logic resetn,
    pms_attr_if.tbl  at
);
    import pms_pkg::*;
    logic [VAL_W-1:0] mem_q [N_ATTR];
    logic [N_ATTR-1:0] hit;
    logic [N_ATTR-1:0] ok;
    logic [VAL_W-1:0]  sel;

    // one id comparator and one range comparator pair per attribute
    always_comb begin
        sel = '0;
        for (int i = 0; i < N_ATTR; i++) begin
            hit[i] = (at.id == ATTR_ID[i]);
            ok[i]  = hit[i] && (at.wr_val >= ATTR_MIN[i]) && (at.wr_val <= ATTR_MAX[i]);
            if (hit[i]) begin
                sel = mem_q[i];
            end
        end
    end
    assign at.found    = |hit;
    assign at.in_range = |ok;
    assign at.rd_val   = sel;

    // storage only changes on a checked write of a present, in-range attribute
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < N_ATTR; i++) mem_q[i] <= ATTR_RST[i];
        end else if (at.wr_en) begin
            for (int i = 0; i < N_ATTR; i++) if (ok[i]) mem_q[i] <= at.wr_val;
        end
    end
endmodule : pms_attr_tbl

// ===== tb/pms_burst_xmtr.sv
// model of the burst transmitter that sits behind burst_start and burst_done
// assumes the same clk as pms_top; the send time is set per run by the bench
`timescale 1ns/10ps
module pms_burst_xmtr (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       burst_start,
    input  wire logic [3:0] send_cycles,
    output logic            burst_done
);
    logic [3:0] cnt_q;
    logic       run_q;

    // counts the send time, then reports once; a start while sending is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_q      <= 1'b0;
            cnt_q      <= 4'h0;
            burst_done <= 1'b0;
        end else begin
            burst_done <= 1'b0;
            if (burst_start && !run_q) begin
                run_q <= 1'b1;
                cnt_q <= send_cycles;
            end else if (run_q) begin
                if (cnt_q <= 4'h1) begin // done only after the burst is out
                    run_q      <= 1'b0;
                    burst_done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule : pms_burst_xmtr

// ===== tb/phy_management_service_tb_top.sv
// self-checking bench for pms_top with the burst transmitter model
// assumes inputs change at the falling edge and non-burst confirms arrive one cycle later
`timescale 1ns/10ps
module phy_management_service_tb_top;
    import pms_pkg::*;
    logic        clk, resetn, rd_req, wr_req, bu_req, st_req, burst_done, burst_start;
    logic        cnf_valid, busy, done_seen;
    logic [7:0]  attr_id, cnf_attr_id;
    logic [15:0] attr_value, cnf_value;
    logic [1:0]  tgt, xcvr_state, cnf_kind, cnf_status;
    logic [4:0]  cnf_value_len;
    logic [3:0]  send_cycles;
    int          miscompares, samples_checked, cycles;

    pms_top pms_top_i (.clk(clk), .resetn(resetn), .attr_read_req(rd_req),
        .attr_write_req(wr_req), .burst_initiate_req(bu_req), .xcvr_state_set_req(st_req),
        .attr_id(attr_id), .attr_value(attr_value), .xcvr_target_state(tgt),
        .burst_done(burst_done), .burst_start(burst_start), .xcvr_state(xcvr_state),
        .cnf_valid(cnf_valid), .cnf_kind(cnf_kind), .cnf_status(cnf_status),
        .cnf_attr_id(cnf_attr_id), .cnf_value(cnf_value), .cnf_value_len(cnf_value_len),
        .busy(busy));
    pms_burst_xmtr pms_burst_xmtr_i (.clk(clk), .resetn(resetn), .burst_start(burst_start),
        .send_cycles(send_cycles), .burst_done(burst_done));

    // 200 MHz clock, hang guard and a note of the transmitter's report
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (burst_done === 1'b1) done_seen <= 1'b1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // one request pulse; returns at the falling edge where its confirm stands, or burst_start for a burst
    task automatic send(input int kind, input logic [7:0] id, input logic [15:0] val,
                        input logic [1:0] st);
        @(negedge clk);
        attr_id    = id;
        attr_value = val;
        tgt        = st;
        rd_req     = (kind == 0);
        wr_req     = (kind == 1);
        bu_req     = (kind == 2);
        st_req     = (kind == 3);
        @(negedge clk);
        {rd_req, wr_req, bu_req, st_req} = 4'h0;
    endtask : send

    task automatic expect_cnf(input logic [1:0] k, input logic [1:0] st, input logic [7:0] id,
                              input logic [15:0] v, input logic [4:0] len);
        check("cnf_valid", cnf_valid, 1'b1);
        check("cnf_kind", cnf_kind, k);
        check("cnf_status", cnf_status, st);
        check("cnf_attr_id", cnf_attr_id, id);
        check("cnf_value", cnf_value, v);
        check("cnf_value_len", cnf_value_len, len);
    endtask : expect_cnf

    task automatic test_read_write();
        for (int i = 0; i < N_ATTR; i++) begin
            send(0, ATTR_ID[i], 16'h0000, 2'h0);
            expect_cnf(CK_READ, ST_SUCCESS, ATTR_ID[i], ATTR_RST[i], VAL_LEN);
        end
        send(1, 8'h01, 16'h0003, 2'h0);
        expect_cnf(CK_WRITE, ST_SUCCESS, 8'h01, 16'h0000, LEN_NONE);
        send(1, 8'h01, 16'h0004, 2'h0);
        expect_cnf(CK_WRITE, ST_INVALID, 8'h01, 16'h0000, LEN_NONE);
        send(1, 8'h02, 16'h0000, 2'h0);
        expect_cnf(CK_WRITE, ST_INVALID, 8'h02, 16'h0000, LEN_NONE);
        send(0, 8'h01, 16'h0000, 2'h0);
        expect_cnf(CK_READ, ST_SUCCESS, 8'h01, 16'h0003, VAL_LEN);
        send(1, 8'h03, 16'hFFFF, 2'h0);
        expect_cnf(CK_WRITE, ST_SUCCESS, 8'h03, 16'h0000, LEN_NONE);
        send(0, 8'h03, 16'h0000, 2'h0);
        expect_cnf(CK_READ, ST_SUCCESS, 8'h03, 16'hFFFF, VAL_LEN);
        send(1, 8'h05, 16'h0001, 2'h0);
        expect_cnf(CK_WRITE, ST_NOT_FOUND, 8'h05, 16'h0000, LEN_NONE);
        send(0, 8'h05, 16'h0000, 2'h0);
        expect_cnf(CK_READ, ST_NOT_FOUND, 8'h05, 16'h0000, LEN_NONE);
        // a confirm stands for one cycle only
        @(negedge clk);
        check("cnf_valid", cnf_valid, 1'b0);
        $display("read and write test done");
    endtask : test_read_write

    task automatic test_state();
        logic [1:0] seq [4] = '{XS_TX, XS_RX, XS_OFF, XS_RX};
        foreach (seq[i]) begin
            send(3, 8'h00, 16'h0000, seq[i]);
            expect_cnf(CK_STATE, ST_COMPLETE, 8'h00, 16'h0000, LEN_NONE);
            check("xcvr_state", xcvr_state, seq[i]);
        end
        send(3, 8'h00, 16'h0000, 2'h3);
        check("xcvr_state", xcvr_state, XS_RX);
        resetn = 1'b0;
        @(negedge clk);
        check("xcvr_state", xcvr_state, XS_OFF);
        check("cnf_valid", cnf_valid, 1'b0);
        resetn = 1'b1;
        $display("transceiver state test done");
    endtask : test_state

    task automatic test_burst();
        int n;
        logic [3:0] dly [2] = '{4'h1, 4'h7};
        foreach (dly[i]) begin
            send_cycles = dly[i];
            done_seen   = 1'b0;
            send(2, 8'h00, 16'h0000, 2'h0);
            check("burst_start", burst_start, 1'b1);
            check("busy", busy, 1'b1);
            if (dly[i] > 4'h2) begin
                send(0, 8'h01, 16'h0000, 2'h0);
                check("cnf_valid", cnf_valid, 1'b0);
            end
            n = 0;
            while (cnf_valid !== 1'b1 && n < 40) begin
                @(negedge clk);
                n++;
            end
            check("done_seen", done_seen, 1'b1);
            expect_cnf(CK_BURST, ST_COMPLETE, 8'h00, 16'h0000, LEN_NONE);
            check("busy", busy, 1'b0);
        end
        $display("burst test done");
    endtask : test_burst

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // reset for three cycles, then run each scenario in turn
    initial begin
        {clk, rd_req, wr_req, bu_req, st_req, done_seen} = 6'h00;
        {attr_id, attr_value, tgt} = 26'h0;
        send_cycles = 4'h1;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        test_read_write();
        test_state();
        test_burst();
        final_report();
    end
endmodule : phy_management_service_tb_top
